// *** logic/mcp_pkg.sv ***
/*
 * Shared constants and types of the motor current protection supervisor.
 * Assumes currents are given in percent of rated motor current, delays in
 * ticks of the protection time base.
 */
package mcp_pkg;

	// System clock and protection tick
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned TICK_MS = 100;
	localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

	// Widths of levels (percent of rated) and delays (ticks)
	localparam int LVL_W = 16;
	localparam int DLY_W = 16;

	// Current thresholds in percent of rated motor current
	localparam logic [15:0] STARTUP_END_PCT = 16'h0087;
	localparam logic [15:0] PL_RUN_PCT = 16'h0019;
	localparam logic [15:0] PL_LOST_PCT = 16'h000a;

	// Class times in milliseconds and their tick counts
	localparam int unsigned CLASS5_MS = 1500;
	localparam int unsigned CLASS10_MS = 3000;
	localparam int unsigned CLASS20_MS = 6000;
	localparam int unsigned CLASS30_MS = 9000;
	localparam int unsigned CLASS40_MS = 12000;
	localparam logic [15:0] CLASS5_TICKS = 16'(CLASS5_MS / TICK_MS);
	localparam logic [15:0] CLASS10_TICKS = 16'(CLASS10_MS / TICK_MS);
	localparam logic [15:0] CLASS20_TICKS = 16'(CLASS20_MS / TICK_MS);
	localparam logic [15:0] CLASS30_TICKS = 16'(CLASS30_MS / TICK_MS);
	localparam logic [15:0] CLASS40_TICKS = 16'(CLASS40_MS / TICK_MS);

	// Delay qualifier channels
	localparam int CH_BR = 0;
	localparam int CH_HCW = 1;
	localparam int CH_HCT = 2;
	localparam int CH_LCW = 3;
	localparam int CH_LCT = 4;
	localparam int CH_PL = 5;
	localparam int NUM_CH = 6;

	typedef enum logic [2:0] {
		CLASS_5, CLASS_10, CLASS_20, CLASS_30, CLASS_40
	} mcp_class_t;

	typedef enum logic [1:0] {
		ST_IDLE, ST_STARTUP, ST_RUN, ST_TRIP
	} mcp_state_t;

	// Class time in ticks; unused codes fall back to the longest class
	function automatic logic [15:0] class_ticks(input logic [2:0] c);
		unique case (c)
			3'h0: class_ticks = CLASS5_TICKS;
			3'h1: class_ticks = CLASS10_TICKS;
			3'h2: class_ticks = CLASS20_TICKS;
			3'h3: class_ticks = CLASS30_TICKS;
			default: class_ticks = CLASS40_TICKS;
		endcase
	endfunction : class_ticks

endpackage : mcp_pkg

// *** logic/mcp_qual_if.sv ***
/*
 * Link between the supervisor and one delay qualifier.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface mcp_qual_if;
	logic cond;
	logic [15:0] limit;
	logic hit;
	modport ctl (output cond, output limit, input hit);
	modport qual (input cond, input limit, output hit);
endinterface : mcp_qual_if

// *** logic/mcp_qualifier.sv ***
/*
 * Delay qualifier: hit rises once the condition has held for limit ticks.
 * Assumes a one-cycle tick enable from the supervisor's divider.
 */
`timescale 1ns/1ps
module mcp_qualifier (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Time base
	input wire logic tick,
	// Condition, limit and result
	mcp_qual_if.qual q
);

	logic [15:0] cnt_reg, cnt_next;
	logic hit_reg, hit_next;

	// Count ticks while the condition holds; any lapse restarts from zero
	always_comb begin
		cnt_next = cnt_reg;
		hit_next = 1'b0;
		if (!q.cond) begin
			cnt_next = 16'h0000;
		end else begin
			if (tick && cnt_reg < q.limit) begin
				cnt_next = cnt_reg + 16'h0001;
			end
			hit_next = (cnt_next >= q.limit);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 16'h0000;
			hit_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			hit_reg <= hit_next;
		end
	end

	assign q.hit = hit_reg;

	a_lapse_clears: assert property (@(posedge clk) disable iff (!rst_n)
		!q.cond |=> !q.hit && cnt_reg == 16'h0000)
		else $error("qualifier did not restart after lapse");

endmodule : mcp_qualifier

// *** logic/mcp_supervisor.sv ***
/*
 * Motor current protection supervisor: start-up tracking, blocked rotor,
 * high and low current, phase loss and restart inhibit.
 * Assumes currents and settings come from logic on clk, in percent of
 * rated motor current, and that start, stop and reset are pulses on clk.
 */
// Behaviour
// - Blocked rotor trip when current exceeds its level for its delay
// - Blocked rotor gives a trip only; level and delay are settable
// - Blocked rotor check runs only during start-up
// - Start-up ends at 135 % current or when the class time runs out
// - Class time counting begins with the start command
// - After start-up a blocked rotor is caught by high current
// - High current warning after current stays above level for delay
// - High current trip after current stays above trip level for delay
// - Short high excursion does not trip; timing restarts next time
// - High current trip stops the motor
// - Low current warning after current stays below level for delay
// - Low current trip after current stays below trip level for delay
// - Short low dip that recovers does not trip
// - Persisting low current trips and stops the motor
// - Phase loss trips after the class time while running
// - Phase loss flags the thermal model for accelerated tripping
// - Restart-level mode blocks restart until thermal load drops
`timescale 1ns/1ps
module mcp_supervisor #(
	parameter int unsigned TICK_CYCLES = mcp_pkg::TICK_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Commands
	input wire logic start_cmd,
	input wire logic stop_cmd,
	input wire logic fault_reset,
	// Phase currents, percent of rated_motor_current
	input wire logic [15:0] cur_l1,
	input wire logic [15:0] cur_l2,
	input wire logic [15:0] cur_l3,
	// Settings
	input wire logic [2:0] trip_class,
	input wire logic blocked_rotor_en,
	input wire logic [15:0] blocked_rotor_level,
	input wire logic [15:0] blocked_rotor_delay,
	input wire logic hc_en,
	input wire logic [15:0] hc_warn_level,
	input wire logic [15:0] hc_warn_delay,
	input wire logic [15:0] hc_trip_level,
	input wire logic [15:0] hc_trip_delay,
	input wire logic lc_en,
	input wire logic [15:0] lc_warn_level,
	input wire logic [15:0] lc_warn_delay,
	input wire logic [15:0] lc_trip_level,
	input wire logic [15:0] lc_trip_delay,
	input wire logic pl_en,
	// Thermal model link
	input wire logic ovl_trip,
	input wire logic restart_level_mode,
	input wire logic [7:0] thermal_load,
	input wire logic [7:0] restart_level,
	input wire logic cool_time_done,
	// Status and contactor
	output logic motor_run,
	output logic startup_active,
	output logic blocked_rotor_trip,
	output logic hc_warn,
	output logic hc_trip,
	output logic lc_warn,
	output logic lc_trip,
	output logic pl_trip,
	output logic pl_accel,
	output logic start_inhibit
);

	localparam logic [21:0] DIV_LAST = 22'(TICK_CYCLES - 1);

	mcp_pkg::mcp_state_t state_reg, state_next;
	logic [21:0] div_reg, div_next;
	logic tick_reg, tick_next;
	logic [15:0] cls_reg, cls_next;
	logic [15:0] cur_max, cur_min;
	logic [mcp_pkg::NUM_CH-1:0] cond, hit;
	logic [15:0] lim [mcp_pkg::NUM_CH];
	logic run_like, trip_now, startup_done;
	logic br_reg, br_next, hct_reg, hct_next, lct_reg, lct_next;
	logic pl_reg, pl_next, hcw_reg, lcw_reg, acc_reg;
	logic lock_reg, lock_next, inh_reg, inh_next, run_reg, su_reg;

	function automatic logic [15:0] max2(input logic [15:0] a, b);
		max2 = (a > b) ? a : b;
	endfunction : max2

	function automatic logic [15:0] min2(input logic [15:0] a, b);
		min2 = (a < b) ? a : b;
	endfunction : min2

	// Motor current is the highest phase; the lowest reveals a lost phase
	assign cur_max = max2(max2(cur_l1, cur_l2), cur_l3);
	assign cur_min = min2(min2(cur_l1, cur_l2), cur_l3);

	// Tick divider: every delay shares this one time base
	always_comb begin
		tick_next = (div_reg == DIV_LAST);
		div_next = tick_next ? 22'h000000 : div_reg + 22'h000001;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_reg <= 22'h000000;
			tick_reg <= 1'b0;
		end else begin
			div_reg <= div_next;
			tick_reg <= tick_next;
		end
	end

	// Qualifier conditions, each gated by the phase it belongs to
	assign run_like = (state_reg == mcp_pkg::ST_STARTUP) ||
		(state_reg == mcp_pkg::ST_RUN);
	always_comb begin
		cond[mcp_pkg::CH_BR] = (state_reg == mcp_pkg::ST_STARTUP) &&
			blocked_rotor_en && cur_max > blocked_rotor_level;
		cond[mcp_pkg::CH_HCW] = (state_reg == mcp_pkg::ST_RUN) && hc_en &&
			cur_max > hc_warn_level;
		cond[mcp_pkg::CH_HCT] = (state_reg == mcp_pkg::ST_RUN) && hc_en &&
			cur_max > hc_trip_level;
		cond[mcp_pkg::CH_LCW] = (state_reg == mcp_pkg::ST_RUN) && lc_en &&
			cur_max < lc_warn_level;
		cond[mcp_pkg::CH_LCT] = (state_reg == mcp_pkg::ST_RUN) && lc_en &&
			cur_max < lc_trip_level;
		cond[mcp_pkg::CH_PL] = run_like && pl_en &&
			cur_max > mcp_pkg::PL_RUN_PCT &&
			cur_min < mcp_pkg::PL_LOST_PCT;
		lim[mcp_pkg::CH_BR] = blocked_rotor_delay;
		lim[mcp_pkg::CH_HCW] = hc_warn_delay;
		lim[mcp_pkg::CH_HCT] = hc_trip_delay;
		lim[mcp_pkg::CH_LCW] = lc_warn_delay;
		lim[mcp_pkg::CH_LCT] = lc_trip_delay;
		lim[mcp_pkg::CH_PL] = mcp_pkg::class_ticks(trip_class);
	end

	// One delay qualifier per protection channel
	mcp_qual_if qi [mcp_pkg::NUM_CH] ();
	generate
		for (genvar i = 0; i < mcp_pkg::NUM_CH; i++) begin : g_ch
			assign qi[i].cond = cond[i];
			assign qi[i].limit = lim[i];
			assign hit[i] = qi[i].hit;
			mcp_qualifier u_qual (
				.clk(clk),
				.rst_n(rst_n),
				.tick(tick_reg),
				.q(qi[i])
			);
		end
	endgenerate

	// Trip latches: a new trip wins over a fault reset in the same cycle
	always_comb begin
		br_next = hit[mcp_pkg::CH_BR] || (br_reg && !fault_reset);
		hct_next = hit[mcp_pkg::CH_HCT] || (hct_reg && !fault_reset);
		lct_next = hit[mcp_pkg::CH_LCT] || (lct_reg && !fault_reset);
		pl_next = hit[mcp_pkg::CH_PL] || (pl_reg && !fault_reset);
		trip_now = hit[mcp_pkg::CH_BR] || hit[mcp_pkg::CH_HCT] ||
			hit[mcp_pkg::CH_LCT] || hit[mcp_pkg::CH_PL] || ovl_trip;
	end

	// Start-up ends on current drop or when the class time has run out
	assign startup_done = cur_max <= mcp_pkg::STARTUP_END_PCT ||
		cls_reg >= mcp_pkg::class_ticks(trip_class);

	// Motor state machine and class time counter
	always_comb begin
		state_next = state_reg;
		cls_next = cls_reg;
		if (state_reg == mcp_pkg::ST_STARTUP && tick_reg &&
			cls_reg != 16'hffff) begin
			cls_next = cls_reg + 16'h0001;
		end
		unique case (state_reg)
			mcp_pkg::ST_IDLE: begin
				if (start_cmd && !inh_reg) begin
					state_next = mcp_pkg::ST_STARTUP;
					cls_next = 16'h0000;
				end
			end
			mcp_pkg::ST_STARTUP: begin
				if (trip_now) begin
					state_next = mcp_pkg::ST_TRIP;
				end else if (stop_cmd) begin
					state_next = mcp_pkg::ST_IDLE;
				end else if (startup_done) begin
					state_next = mcp_pkg::ST_RUN;
				end
			end
			mcp_pkg::ST_RUN: begin
				if (trip_now) begin
					state_next = mcp_pkg::ST_TRIP;
				end else if (stop_cmd) begin
					state_next = mcp_pkg::ST_IDLE;
				end
			end
			mcp_pkg::ST_TRIP: begin
				if (fault_reset && !trip_now) begin
					state_next = mcp_pkg::ST_IDLE;
				end
			end
		endcase
	end

	// Restart lock after an overload trip; a new trip wins over release
	always_comb begin
		lock_next = lock_reg;
		if (restart_level_mode ? thermal_load <= restart_level
			: cool_time_done) begin
			lock_next = 1'b0;
		end
		if (ovl_trip) begin
			lock_next = 1'b1;
		end
		inh_next = lock_next;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= mcp_pkg::ST_IDLE;
			cls_reg <= 16'h0000;
			br_reg <= 1'b0;
			hct_reg <= 1'b0;
			lct_reg <= 1'b0;
			pl_reg <= 1'b0;
			hcw_reg <= 1'b0;
			lcw_reg <= 1'b0;
			acc_reg <= 1'b0;
			lock_reg <= 1'b0;
			inh_reg <= 1'b0;
			run_reg <= 1'b0;
			su_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cls_reg <= cls_next;
			br_reg <= br_next;
			hct_reg <= hct_next;
			lct_reg <= lct_next;
			pl_reg <= pl_next;
			hcw_reg <= hit[mcp_pkg::CH_HCW];
			lcw_reg <= hit[mcp_pkg::CH_LCW];
			acc_reg <= cond[mcp_pkg::CH_PL];
			lock_reg <= lock_next;
			inh_reg <= inh_next;
			run_reg <= state_next == mcp_pkg::ST_STARTUP ||
				state_next == mcp_pkg::ST_RUN;
			su_reg <= state_next == mcp_pkg::ST_STARTUP;
		end
	end

	// All outputs straight from flip-flops
	assign motor_run = run_reg;
	assign startup_active = su_reg;
	assign blocked_rotor_trip = br_reg;
	assign hc_warn = hcw_reg;
	assign hc_trip = hct_reg;
	assign lc_warn = lcw_reg;
	assign lc_trip = lct_reg;
	assign pl_trip = pl_reg;
	assign pl_accel = acc_reg;
	assign start_inhibit = inh_reg;

	// Start-up exit by current and by class time
	sequence s_in_startup;
		state_reg == mcp_pkg::ST_STARTUP && !trip_now && !stop_cmd;
	endsequence
	sequence s_reach_run;
		##1 state_reg == mcp_pkg::ST_RUN && !su_reg;
	endsequence

	a_startup_cur_end: assert property (@(posedge clk) disable iff (!rst_n)
		s_in_startup ##0 cur_max <= mcp_pkg::STARTUP_END_PCT
		|-> s_reach_run)
		else $error("start-up did not end at 135 percent");
	a_startup_class_end: assert property (@(posedge clk) disable iff (!rst_n)
		s_in_startup ##0 cls_reg >= mcp_pkg::class_ticks(trip_class)
		|-> s_reach_run)
		else $error("start-up did not end at class time");
	a_class_start: assert property (@(posedge clk) disable iff (!rst_n)
		state_reg == mcp_pkg::ST_IDLE && start_cmd && !inh_reg
		|=> cls_reg == 16'h0000 && su_reg)
		else $error("class timer not started by start command");
	a_br_only_startup: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(br_reg) |-> $past(state_reg, 2) == mcp_pkg::ST_STARTUP)
		else $error("blocked rotor trip outside start-up");
	a_trip_stops: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(hct_reg) || $rose(lct_reg) || $rose(br_reg)
		|-> !run_reg && state_reg == mcp_pkg::ST_TRIP)
		else $error("trip did not stop the motor");
	a_hcw_clear: assert property (@(posedge clk) disable iff (!rst_n)
		!cond[mcp_pkg::CH_HCW] |-> ##2 !hcw_reg)
		else $error("high current warning held after lapse");
	a_lcw_timing: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(lcw_reg) |-> $past(cond[mcp_pkg::CH_LCW], 2))
		else $error("low current warning without condition");
	a_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
		fault_reset && hit[mcp_pkg::CH_HCT] |=> hct_reg)
		else $error("trip lost against fault reset");
	a_pl_accel: assert property (@(posedge clk) disable iff (!rst_n)
		cond[mcp_pkg::CH_PL] |=> acc_reg)
		else $error("phase loss not flagged to thermal model");
	a_inhibit_start: assert property (@(posedge clk) disable iff (!rst_n)
		inh_reg && state_reg == mcp_pkg::ST_IDLE
		|=> state_reg == mcp_pkg::ST_IDLE)
		else $error("start allowed while restart locked");

endmodule : mcp_supervisor

// *** tb/mcp_front_end.sv ***
/*
 * Current front end and contactor model: phase currents follow the load.
 * Assumes the bench sets the load level and the lost phase on clk.
 */
`timescale 1ns/1ps
module mcp_front_end (
	// Contactor command
	input wire logic motor_run,
	// Load set by the bench
	input wire logic [15:0] level,
	input wire logic lost,
	// Measured phase currents
	output logic [15:0] cur_l1,
	output logic [15:0] cur_l2,
	output logic [15:0] cur_l3
);
	// No current flows while the contactor is open
	always_comb begin
		cur_l1 = motor_run ? level : 16'h0000;
		cur_l2 = motor_run ? level : 16'h0000;
		cur_l3 = (motor_run && !lost) ? level : 16'h0000; // Broken phase wire
	end
endmodule : mcp_front_end

// *** tb/motor_current_protection_tb.sv ***
/*
 * Testbench of the motor current protection supervisor.
 * Assumes a short tick of 10 clocks so that class times stay cheap.
 */
`timescale 1ns/1ps
module motor_current_protection_tb;
	localparam int TK = 10;
	localparam int MR = 9, SU = 8, BR = 7, HW = 6, HT = 5;
	localparam int LW = 4, LT = 3, PT = 2, PA = 1, SI = 0;
	logic clk, rst_n, lost, hc_en, lc_en, pl_en, br_en, rlm, cool;
	logic [3:0] cmd;
	logic [2:0] tclass;
	logic [15:0] load, c1, c2, c3, br_lvl, br_dly, hw_lvl, hw_dly;
	logic [15:0] ht_lvl, ht_dly, lw_lvl, lw_dly, lt_lvl, lt_dly;
	logic [7:0] therm, rlvl;
	wire [9:0] st;
	int n_fail = 0, tests_run = 0, cycles = 0;
	int ct[5] = '{15, 30, 60, 90, 120};

	mcp_front_end i_mcp_front_end (.motor_run(st[MR]), .level(load),
		.lost(lost), .cur_l1(c1), .cur_l2(c2), .cur_l3(c3));

	mcp_supervisor #(.TICK_CYCLES(TK)) i_mcp_supervisor (.clk(clk),
		.rst_n(rst_n), .start_cmd(cmd[0]), .stop_cmd(cmd[1]),
		.fault_reset(cmd[2]), .cur_l1(c1), .cur_l2(c2), .cur_l3(c3),
		.trip_class(tclass), .blocked_rotor_en(br_en),
		.blocked_rotor_level(br_lvl), .blocked_rotor_delay(br_dly),
		.hc_en(hc_en), .hc_warn_level(hw_lvl), .hc_warn_delay(hw_dly),
		.hc_trip_level(ht_lvl), .hc_trip_delay(ht_dly), .lc_en(lc_en),
		.lc_warn_level(lw_lvl), .lc_warn_delay(lw_dly),
		.lc_trip_level(lt_lvl), .lc_trip_delay(lt_dly), .pl_en(pl_en),
		.ovl_trip(cmd[3]), .restart_level_mode(rlm), .thermal_load(therm),
		.restart_level(rlvl), .cool_time_done(cool),
		.motor_run(st[MR]), .startup_active(st[SU]),
		.blocked_rotor_trip(st[BR]), .hc_warn(st[HW]), .hc_trip(st[HT]),
		.lc_warn(st[LW]), .lc_trip(st[LT]), .pl_trip(st[PT]),
		.pl_accel(st[PA]), .start_inhibit(st[SI]));

	// Free-running clock, 40 ns period
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic print_verdict();
		$display("Checks %0d, failures %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict

	// Hang guard: the whole run needs well under this many cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			$display("FAIL %0t timeout", $time);
			print_verdict();
		end
	end

	task automatic chk_bit(input int i, input logic e);
		tests_run++;
		if (st[i] !== e) begin
			n_fail++;
			$display("FAIL %0t output %0d is %b", $time, i, st[i]);
		end
	endtask : chk_bit

	// Waits for an output level; it must not come before lo cycles
	task automatic chk_time(input int i, input logic e, input int lo,
		input int hi);
		int n;
		n = 0;
		while (st[i] !== e && n < hi) begin
			@(posedge clk);
			#1;
			n++;
		end
		tests_run++;
		if (st[i] !== e || n < lo) begin
			n_fail++;
			$display("FAIL %0t output %0d after %0d cycles", $time, i, n);
		end
	endtask : chk_time

	// One-cycle command pulse: 0 start, 1 stop, 2 fault reset, 3 overload
	task automatic pulse(input int k);
		@(posedge clk);
		cmd[k] <= 1'b1;
		@(posedge clk);
		cmd[k] <= 1'b0;
		#1;
	endtask : pulse

	task automatic setl(input logic [15:0] v);
		@(posedge clk);
		load <= v;
		#1;
	endtask : setl

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : idle

	// Main sequence
	initial begin
		rst_n = 1'b0; cmd = 4'h0; lost = 1'b0; load = 16'h0258;
		tclass = 3'h0; br_en = 1'b1; br_lvl = 16'h01f4; br_dly = 16'h0003;
		hc_en = 1'b0; hw_lvl = 16'hffff; hw_dly = 16'h0003;
		ht_lvl = 16'h01f4; ht_dly = 16'h0064; lc_en = 1'b0;
		lw_lvl = 16'h0050; lw_dly = 16'h0003; lt_lvl = 16'h0032;
		lt_dly = 16'h0005; pl_en = 1'b0; rlm = 1'b1; cool = 1'b0;
		therm = 8'h50; rlvl = 8'h3c;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		for (int i = 0; i < 10; i++) chk_bit(i, 1'b0);
		// Stalled start trips on the blocked rotor level
		pulse(0);
		chk_bit(SU, 1'b1);
		chk_time(BR, 1'b1, 2 * TK, 4 * TK + 4);
		chk_bit(HW, 1'b0);
		chk_bit(MR, 1'b0);
		pulse(2);
		chk_bit(BR, 1'b0);
		// Each class time ends a long start; blocked rotor too slow here
		@(posedge clk);
		br_dly <= 16'h00c8;
		hc_en <= 1'b1;
		for (int c = 0; c < 5; c++) begin
			@(posedge clk);
			tclass <= 3'(c);
			pulse(0);
			chk_time(SU, 1'b0, (ct[c] - 1) * TK, (ct[c] + 1) * TK + 4);
			chk_bit(MR, 1'b1);
			if (c < 4) pulse(1);
		end
		// Still high after start-up: high current trips, blocked rotor not
		chk_time(HT, 1'b1, 99 * TK, 101 * TK + 4);
		chk_bit(BR, 1'b0);
		chk_bit(MR, 1'b0);
		pulse(2);
		// Start-up ends at 135 % but not one percent above
		for (int k = 0; k < 2; k++) begin
			setl(16'h0087 + 16'(k));
			pulse(0);
			idle(1);
			chk_bit(SU, k[0]);
			pulse(1);
		end
		// High current warning, short excursion, then a real trip
		@(posedge clk);
		hw_lvl <= 16'h0096;
		ht_lvl <= 16'h00c8;
		ht_dly <= 16'h0005;
		setl(16'h0087);
		pulse(0);
		setl(16'h00a0);
		chk_time(HW, 1'b1, 2 * TK, 4 * TK + 4);
		setl(16'h00fa);
		idle(3 * TK);
		setl(16'h00a0);
		idle(6 * TK);
		chk_bit(HT, 1'b0);
		setl(16'h0064);
		chk_time(HW, 1'b0, 0, 4);
		setl(16'h00fa);
		chk_time(HT, 1'b1, 4 * TK, 6 * TK + 4);
		chk_bit(MR, 1'b0);
		pulse(2);
		// Low current warning, short dip, then persisting low load
		@(posedge clk);
		hc_en <= 1'b0;
		lc_en <= 1'b1;
		setl(16'h0087);
		pulse(0);
		setl(16'h0046);
		chk_time(LW, 1'b1, 2 * TK, 4 * TK + 4);
		setl(16'h0028);
		idle(3 * TK);
		setl(16'h0064);
		chk_time(LW, 1'b0, 0, 4);
		idle(6 * TK);
		chk_bit(LT, 1'b0);
		setl(16'h0028);
		chk_time(LT, 1'b1, 4 * TK, 6 * TK + 4);
		chk_bit(MR, 1'b0);
		pulse(2);
		// Lost phase while running, class 5
		@(posedge clk);
		lc_en <= 1'b0;
		pl_en <= 1'b1;
		tclass <= 3'h0;
		lost <= 1'b1;
		setl(16'h0087);
		pulse(0);
		chk_time(PA, 1'b1, 0, 4);
		chk_time(PT, 1'b1, 13 * TK, 16 * TK + 4);
		chk_bit(MR, 1'b0);
		pulse(2);
		// Overload trip, restart held until thermal load is low enough
		@(posedge clk);
		pl_en <= 1'b0;
		lost <= 1'b0;
		pulse(0);
		pulse(3);
		chk_time(SI, 1'b1, 0, 4);
		chk_bit(MR, 1'b0);
		pulse(2);
		pulse(0);
		chk_bit(MR, 1'b0);
		@(posedge clk);
		therm <= 8'h32;
		chk_time(SI, 1'b0, 0, 8);
		pulse(0);
		chk_bit(MR, 1'b1);
		// Fixed cooling mode: thermal load is low, only the timer releases
		@(posedge clk);
		rlm <= 1'b0;
		pulse(3);
		chk_time(SI, 1'b1, 0, 4);
		pulse(2);
		idle(4);
		chk_bit(SI, 1'b1);
		@(posedge clk);
		cool <= 1'b1;
		chk_time(SI, 1'b0, 0, 8);
		print_verdict();
	end
endmodule : motor_current_protection_tb
